// ===== design/pmd_top.sv
// What this block does
// [R1] Answer frames for own address 1..7; also take writes sent to address 0.
// [R2] Management address comes from three-bit strap caught at reset.
// [R3] Station sends 32 ones, start 01, opcode 10 read or 01 write.
// [R4] Then device and register address, turnaround, sixteen data bits, idle.
// [R5] All registers are 16 bits; low addresses standard, high ones extended.
// [R6] Two wires: station clock plus one shared bidirectional data line.
// [R7] Interrupt register: enables high byte, status low byte, output gated by enables.
// [R8] Reading interrupt register clears all status bits and the output.
// [R9] Control-two bit 9 picks interrupt polarity, active low after reset.
// [R10] Both lights active low; default link-activity and speed, field selects link and activity.
// [R11] Small package shared pin is light until EEE enabled and partner agrees.
// [R12] Link-activity: steady on when idle, blink on traffic; activity blinks only.
// [R13] Speed light on for 100 link; link light on while link up.
// [R14] Auto crossover taken from config strap at reset, then control-two bit 13.
// [R15] Without auto crossover use normal pairs; bit 14 swaps them.
// [R16] Config strap 110 at reset selects back-to-back repeater mode.
// [R17] In repeater mode peer wiring joins receive outputs to transmit inputs.
// [R18] Software sets extended bit 6 for repeater at 10 Mb/s.
// [R19] Local loopback needs basic-control settings and aux bit 5.
// [R20] Local loopback returns MAC transmit frames on the receive side.
// [R21] Control-two bit 2 loops line frames back, only at 100 full duplex.
// [R22] Software forces or negotiates 100 full duplex before remote loopback.
// [R23] At 100 Mb/s receive valid covers preamble through last nibble.
// [R24] Data line released except second turnaround bit and data of own reads.
`timescale 1ns/1ps
module pmd_top #(
    parameter int unsigned BLINK_TICKS = pmd_pkg::BLINK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic mgmt_clk,
    input wire logic mgmt_data_in,
    output logic mgmt_data_out,
    output logic mgmt_data_oe,
    input wire logic [2:0] address_strap,
    input wire logic [2:0] config_strap,
    input wire logic small_package,
    input wire logic partner_eee,
    input wire logic link_up,
    input wire logic link_speed100,
    input wire logic link_full_duplex,
    input wire logic activity,
    input wire logic [7:0] int_events,
    input wire pmd_pkg::pmd_nib_t mac_tx,
    input wire pmd_pkg::pmd_nib_t line_rx,
    output pmd_pkg::pmd_nib_t mac_rx,
    output pmd_pkg::pmd_nib_t line_tx,
    output logic interrupt_output,
    output logic status_light_first,
    output logic status_light_second,
    output logic shared_pin_txer,
    output logic auto_mdix_en,
    output logic mdix_swap,
    output logic b2b_mode,
    output logic b2b_10m,
    output logic local_loopback,
    output logic remote_loopback
);
    typedef enum logic [2:0] {
        MS_PRE,
        MS_START,
        MS_OP,
        MS_PHY,
        MS_REG,
        MS_TA,
        MS_DATA
    } pmd_mstate_t;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [7:0] pins_s;
    logic mdc_s;
    logic mdio_s;
    logic [2:0] addr_s;
    logic [2:0] cfg_s;

    pmd_sync #(.W(8)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .din({mgmt_clk, mgmt_data_in, address_strap, config_strap}),
        .dout(pins_s)
    ); // [R6]

    assign mdc_s = pins_s[7];
    assign mdio_s = pins_s[6];
    assign addr_s = pins_s[5:3];
    assign cfg_s = pins_s[2:0];

    logic mdc_prev_q;
    logic mdc_rise;
    logic mdc_fall;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_prev_q;
    assign mdc_fall = ~mdc_s & mdc_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // strap capture, once after release; sync delay lets pins settle
    logic [1:0] strap_wait_q;
    logic strap_done_q;
    logic strap_take;
    logic [2:0] my_addr_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strap_wait_q <= 2'h0;
            strap_done_q <= 1'b0;
            my_addr_q <= 3'h0;
            b2b_mode <= 1'b0;
        end else if (!strap_done_q) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_take) begin
                strap_done_q <= 1'b1;
                my_addr_q <= addr_s; // [R2]
                b2b_mode <= (cfg_s == pmd_pkg::CFG_B2B); // [R16]
            end
        end
    end

    assign strap_take = (strap_wait_q == 2'h3);

    ////////////////////////////////////////////////////////////////////////
    // management frame engine
    pmd_mstate_t st_q;
    logic [5:0] cnt_q;
    logic [15:0] sh_q;
    logic [1:0] op_q;
    logic [4:0] phy_q;
    logic [4:0] reg_q;
    logic rd_hit_q;
    logic wr_hit_q;
    logic [15:0] rd_q;
    logic wr_en;
    logic rd_take;
    logic [15:0] rd_val;
    logic [4:0] phy_full;
    logic [4:0] reg_full;

    assign phy_full = {phy_q[3:0], mdio_s};
    assign reg_full = {reg_q[3:0], mdio_s};
    assign wr_en = mdc_rise && st_q == pmd_mstate_t'(MS_DATA) && cnt_q == 6'(pmd_pkg::DATA_BITS - 1) && wr_hit_q;
    assign rd_take = mdc_rise && st_q == MS_REG && cnt_q == 6'(pmd_pkg::ADDR_BITS - 1) && op_q == pmd_pkg::OP_READ
        && phy_q[4:3] == 2'h0 && phy_q[2:0] == my_addr_q && my_addr_q != pmd_pkg::BCAST_ADDR;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= MS_PRE;
            cnt_q <= 6'h00;
            sh_q <= 16'h0000;
            op_q <= 2'h0;
            phy_q <= 5'h00;
            reg_q <= 5'h00;
            rd_hit_q <= 1'b0;
            wr_hit_q <= 1'b0;
            rd_q <= 16'h0000;
        end else if (mdc_rise) begin
            unique case (st_q)
                MS_PRE: begin
                    rd_hit_q <= 1'b0;
                    wr_hit_q <= 1'b0;
                    if (mdio_s) begin
                        if (cnt_q != 6'(pmd_pkg::PREAMBLE_ONES)) begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end else if (cnt_q == 6'(pmd_pkg::PREAMBLE_ONES)) begin
                        st_q <= MS_START; // [R3]
                    end else begin
                        cnt_q <= 6'h00;
                    end
                end
                MS_START: begin
                    cnt_q <= 6'h00;
                    st_q <= mdio_s ? MS_OP : MS_PRE; // [R3]
                end
                MS_OP: begin
                    op_q <= {op_q[0], mdio_s};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'(pmd_pkg::OP_BITS - 1)) begin
                        cnt_q <= 6'h00;
                        if ({op_q[0], mdio_s} == pmd_pkg::OP_READ || {op_q[0], mdio_s} == pmd_pkg::OP_WRITE) begin
                            st_q <= MS_PHY; // [R3]
                        end else begin
                            st_q <= MS_PRE;
                        end
                    end
                end
                MS_PHY: begin
                    phy_q <= phy_full;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'(pmd_pkg::ADDR_BITS - 1)) begin
                        cnt_q <= 6'h00;
                        st_q <= MS_REG; // [R4]
                    end
                end
                MS_REG: begin
                    reg_q <= reg_full;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'(pmd_pkg::ADDR_BITS - 1)) begin
                        cnt_q <= 6'h00;
                        st_q <= MS_TA; // [R4]
                        rd_hit_q <= rd_take; // [R1]
                        rd_q <= rd_val;
                        wr_hit_q <= op_q == pmd_pkg::OP_WRITE && phy_q[4:3] == 2'h0
                            && (phy_q[2:0] == my_addr_q || phy_q[2:0] == pmd_pkg::BCAST_ADDR); // [R1]
                    end
                end
                MS_TA: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'(pmd_pkg::TA_BITS - 1)) begin
                        cnt_q <= 6'h00;
                        st_q <= MS_DATA; // [R4]
                    end
                end
                MS_DATA: begin
                    sh_q <= {sh_q[14:0], mdio_s};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'(pmd_pkg::DATA_BITS - 1)) begin
                        cnt_q <= 6'h00;
                        st_q <= MS_PRE; // [R4]
                    end
                end
            endcase
        end
    end

    // drive changes on the falling clock so the station samples stable bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mgmt_data_oe <= 1'b0;
            mgmt_data_out <= 1'b1;
        end else if (mdc_fall) begin
            if (rd_hit_q && st_q == MS_TA && cnt_q == 6'h01) begin
                mgmt_data_oe <= 1'b1; // [R24]
                mgmt_data_out <= 1'b0; // [R4]
            end else if (rd_hit_q && st_q == MS_DATA) begin
                mgmt_data_oe <= 1'b1; // [R24]
                mgmt_data_out <= rd_q[4'(pmd_pkg::DATA_BITS - 1) - cnt_q[3:0]];
            end else begin
                mgmt_data_oe <= 1'b0; // [R24]
                mgmt_data_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] basic_control_q;
    logic [15:0] ext_ctrl_q;
    logic [7:0] int_enable_q;
    logic [7:0] int_status_q;
    logic [15:0] loopback_aux_q;
    logic [15:0] phy_ctrl2_q;
    logic [15:0] wdata;

    assign wdata = {sh_q[14:0], mdio_s};

    always_comb begin
        unique case (reg_full)
            pmd_pkg::REG_BASIC_CONTROL: rd_val = basic_control_q;
            pmd_pkg::REG_EXT_CTRL_B2B_10M: rd_val = ext_ctrl_q;
            pmd_pkg::REG_INT_CTRL_STATUS: rd_val = {int_enable_q, int_status_q};
            pmd_pkg::REG_LOOPBACK_AUX: rd_val = loopback_aux_q;
            pmd_pkg::REG_PHY_CONTROL_TWO: rd_val = phy_ctrl2_q;
            default: rd_val = pmd_pkg::ZERO16; // [R5]
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            basic_control_q <= pmd_pkg::BASIC_CONTROL_RESET;
            ext_ctrl_q <= pmd_pkg::ZERO16;
            int_enable_q <= 8'h00;
            loopback_aux_q <= pmd_pkg::ZERO16;
            phy_ctrl2_q <= pmd_pkg::ZERO16; // [R9]
        end else begin
            if (strap_take && !strap_done_q) begin
                phy_ctrl2_q[pmd_pkg::PC2_AUTO_MDIX] <= ~cfg_s[pmd_pkg::CFG_MDIX_OFF_BIT]; // [R14]
            end
            if (wr_en) begin
                unique case (reg_q)
                    pmd_pkg::REG_BASIC_CONTROL: basic_control_q <= wdata; // [R19]
                    pmd_pkg::REG_EXT_CTRL_B2B_10M: ext_ctrl_q <= wdata; // [R18]
                    pmd_pkg::REG_INT_CTRL_STATUS: int_enable_q <= wdata[15:8]; // [R7]
                    pmd_pkg::REG_LOOPBACK_AUX: loopback_aux_q <= wdata; // [R19]
                    pmd_pkg::REG_PHY_CONTROL_TWO: phy_ctrl2_q <= wdata; // [R14]
                    default: begin
                    end
                endcase
            end
        end
    end

    // status read-clear is taken when the read data is latched; a new event still wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_status_q <= 8'h00;
        end else begin
            int_status_q <= ((rd_take && reg_full == pmd_pkg::REG_INT_CTRL_STATUS) ? 8'h00 : int_status_q)
                | int_events; // [R8]
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_output <= 1'b1;
        end else begin
            interrupt_output <= (|(int_enable_q & int_status_q))
                ~^ phy_ctrl2_q[pmd_pkg::PC2_INT_POL]; // [R7] [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode outputs and data paths
    logic lb_local;
    logic lb_remote;

    assign lb_local = basic_control_q[pmd_pkg::BC_LOOPBACK] & loopback_aux_q[pmd_pkg::AUX_LOOPBACK]
        & ~basic_control_q[pmd_pkg::BC_AUTONEG] & basic_control_q[pmd_pkg::BC_FULL_DUPLEX]; // [R19]
    // remote wrap only when the line really runs 100 full duplex
    assign lb_remote = phy_ctrl2_q[pmd_pkg::PC2_REMOTE_LB] & link_speed100 & link_full_duplex; // [R21] [R22]

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            auto_mdix_en <= 1'b0;
            mdix_swap <= 1'b0;
            b2b_10m <= 1'b0;
            local_loopback <= 1'b0;
            remote_loopback <= 1'b0;
            shared_pin_txer <= 1'b0;
        end else begin
            auto_mdix_en <= phy_ctrl2_q[pmd_pkg::PC2_AUTO_MDIX]; // [R14]
            mdix_swap <= ~phy_ctrl2_q[pmd_pkg::PC2_AUTO_MDIX] & phy_ctrl2_q[pmd_pkg::PC2_MDIX_SWAP]; // [R15]
            b2b_10m <= b2b_mode & ext_ctrl_q[pmd_pkg::EXT_B2B_10M]; // [R18]
            local_loopback <= lb_local;
            remote_loopback <= lb_remote;
            shared_pin_txer <= small_package & loopback_aux_q[pmd_pkg::AUX_EEE_EN] & partner_eee; // [R11]
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mac_rx <= '0;
            line_tx <= '0;
        end else begin
            // line valid is passed whole, preamble included, so a peer can use it as enable
            mac_rx <= lb_local ? mac_tx : line_rx; // [R20] [R23] [R17]
            line_tx <= lb_remote ? line_rx : mac_tx; // [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status lights
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic light0_n;
    pmd_pkg::pmd_light_mode_t mode0;
    pmd_pkg::pmd_light_mode_t mode1;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == BLINK_TICKS - 1) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    assign mode0 = (phy_ctrl2_q[pmd_pkg::PC2_LED_HI:pmd_pkg::PC2_LED_LO] == pmd_pkg::LED_SEL_ALT)
        ? pmd_pkg::LM_LINK : pmd_pkg::LM_LINK_ACT; // [R10]
    assign mode1 = (phy_ctrl2_q[pmd_pkg::PC2_LED_HI:pmd_pkg::PC2_LED_LO] == pmd_pkg::LED_SEL_ALT)
        ? pmd_pkg::LM_ACT : pmd_pkg::LM_SPEED; // [R10]

    pmd_light u_light0 (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .mode(mode0),
        .link_up(link_up),
        .speed100(link_speed100),
        .activity(activity),
        .blink_phase(blink_q),
        .light_n(light0_n)
    );

    pmd_light u_light1 (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .mode(mode1),
        .link_up(link_up),
        .speed100(link_speed100),
        .activity(activity),
        .blink_phase(blink_q),
        .light_n(status_light_second)
    );

    // pin given over to error input shows no light
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_light_first <= 1'b1;
        end else begin
            status_light_first <= shared_pin_txer ? 1'b1 : light0_n; // [R11]
        end
    end
endmodule // pmd_top

// ===== design/pmd_pkg.sv
package pmd_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BLINK_MS = 100;
    localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);

    localparam int unsigned PREAMBLE_ONES = 32;
    localparam int unsigned OP_BITS = 2;
    localparam int unsigned ADDR_BITS = 5;
    localparam int unsigned TA_BITS = 2;
    localparam int unsigned DATA_BITS = 16;

    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [2:0] BCAST_ADDR = 3'h0;

    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_EXT_CTRL_B2B_10M = 5'h18;
    localparam logic [4:0] REG_INT_CTRL_STATUS = 5'h1B;
    localparam logic [4:0] REG_LOOPBACK_AUX = 5'h1C;
    localparam logic [4:0] REG_PHY_CONTROL_TWO = 5'h1F;

    localparam logic [15:0] BASIC_CONTROL_RESET = 16'h3100;
    localparam logic [15:0] ZERO16 = 16'h0000;

    localparam int unsigned BC_LOOPBACK = 14;
    localparam int unsigned BC_SPEED100 = 13;
    localparam int unsigned BC_AUTONEG = 12;
    localparam int unsigned BC_FULL_DUPLEX = 8;
    localparam int unsigned EXT_B2B_10M = 6;
    localparam int unsigned AUX_LOOPBACK = 5;
    localparam int unsigned AUX_EEE_EN = 0;
    localparam int unsigned PC2_MDIX_SWAP = 14;
    localparam int unsigned PC2_AUTO_MDIX = 13;
    localparam int unsigned PC2_INT_POL = 9;
    localparam int unsigned PC2_LED_HI = 5;
    localparam int unsigned PC2_LED_LO = 4;
    localparam int unsigned PC2_REMOTE_LB = 2;

    localparam logic [1:0] LED_SEL_ALT = 2'h1;
    localparam logic [2:0] CFG_B2B = 3'h6;
    localparam int unsigned CFG_MDIX_OFF_BIT = 0;

    typedef enum logic [1:0] {
        LM_LINK_ACT,
        LM_SPEED,
        LM_LINK,
        LM_ACT
    } pmd_light_mode_t;

    typedef struct packed {
        logic dv;
        logic [3:0] d;
    } pmd_nib_t;

endpackage

// ===== design/pmd_sync.sv
`timescale 1ns/1ps
module pmd_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // pmd_sync

// ===== design/pmd_light.sv
`timescale 1ns/1ps
module pmd_light (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pmd_pkg::pmd_light_mode_t mode,
    input wire logic link_up,
    input wire logic speed100,
    input wire logic activity,
    input wire logic blink_phase,
    output logic light_n
);
    logic on;

    always_comb begin
        unique case (mode)
            pmd_pkg::LM_LINK_ACT: on = link_up & (activity ? blink_phase : 1'b1); // [R12]
            pmd_pkg::LM_ACT: on = activity & blink_phase; // [R12]
            pmd_pkg::LM_SPEED: on = link_up & speed100; // [R13]
            pmd_pkg::LM_LINK: on = link_up; // [R13]
        endcase
    end

    // active low drive, dark during reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            light_n <= 1'b1;
        end else begin
            light_n <= ~on; // [R10]
        end
    end
endmodule // pmd_light

// ===== dv/pmd_station.sv
`timescale 1ns/1ps
module pmd_station (
    input wire logic ref_clk,
    input wire logic mgmt_data_in,
    output logic mgmt_clk,
    output logic st_out,
    output logic st_oe
);
    initial begin
        mgmt_clk = 1'b0;
        st_out = 1'b1;
        st_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // clock stands low between frames; sampling just before the fall
    // leaves the device a full high phase to settle its bit
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [16:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            st_oe = !(op == pmd_pkg::OP_READ && i < 18);
            st_out = f[i];
            repeat (4) @(negedge ref_clk);
            mgmt_clk = 1'b1;
            repeat (4) @(negedge ref_clk);
            rd = {rd[15:0], mgmt_data_in};
            mgmt_clk = 1'b0;
        end
        @(negedge ref_clk);
        st_oe = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule // pmd_station

// ===== dv/pmd_chk_sva.sv
`timescale 1ns/1ps
module pmd_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic mgmt_clk,
    input wire logic mgmt_data_oe,
    input wire logic small_package,
    input wire logic partner_eee,
    input wire logic link_up,
    input wire logic link_speed100,
    input wire logic link_full_duplex,
    input wire logic activity,
    input wire pmd_pkg::pmd_nib_t mac_tx,
    input wire pmd_pkg::pmd_nib_t line_rx,
    input wire pmd_pkg::pmd_nib_t mac_rx,
    input wire pmd_pkg::pmd_nib_t line_tx,
    input wire logic status_light_first,
    input wire logic status_light_second,
    input wire logic shared_pin_txer,
    input wire logic auto_mdix_en,
    input wire logic mdix_swap,
    input wire logic b2b_mode,
    input wire logic b2b_10m,
    input wire logic local_loopback,
    input wire logic remote_loopback
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    sequence s_dark;
        (!link_up && !activity && !shared_pin_txer) [*3];
    endsequence
    property p_mac_rx;
        1 |=> mac_rx == (local_loopback ? $past(mac_tx) : $past(line_rx));
    endproperty
    property p_line_tx;
        1 |=> line_tx == (remote_loopback ? $past(line_rx) : $past(mac_tx));
    endproperty
    property p_remote;
        remote_loopback |-> $past(link_speed100) && $past(link_full_duplex);
    endproperty
    property p_txer;
        shared_pin_txer |-> $past(small_package) && $past(partner_eee);
    endproperty
    property p_swap;
        mdix_swap |-> !auto_mdix_en;
    endproperty
    property p_b2b10;
        b2b_10m |-> b2b_mode;
    endproperty
    // drive starts three cycles after the station's falling clock, never after a rise
    property p_oe;
        $rose(mgmt_data_oe) |-> $past(mgmt_clk, 4) && !$past(mgmt_clk, 3)
            && !$past(mgmt_clk, 2);
    endproperty
    property p_dark;
        s_dark |=> status_light_first && status_light_second;
    endproperty
    a_mac_rx: assert property (p_mac_rx) else $error("mac_rx wrong source");
    a_line_tx: assert property (p_line_tx) else $error("line_tx wrong source");
    a_remote: assert property (p_remote) else $error("remote loop off 100 fd");
    a_txer: assert property (p_txer) else $error("shared pin left light");
    a_swap: assert property (p_swap) else $error("swap with auto on");
    a_b2b10: assert property (p_b2b10) else $error("b2b_10m alone");
    a_oe: assert property (p_oe) else $error("drive not after fall");
    a_dark: assert property (p_dark) else $error("light on without link");
endmodule // pmd_chk
bind pmd_top pmd_chk i_pmd_chk (.*);

// ===== dv/pmd_top_bench.sv
`timescale 1ns/1ps
module pmd_top_bench;
    localparam logic [4:0] A = 5'h05;
    localparam logic [4:0] G0 = pmd_pkg::REG_BASIC_CONTROL;
    localparam logic [4:0] G18 = pmd_pkg::REG_EXT_CTRL_B2B_10M;
    localparam logic [4:0] G1B = pmd_pkg::REG_INT_CTRL_STATUS;
    localparam logic [4:0] G1C = pmd_pkg::REG_LOOPBACK_AUX;
    localparam logic [4:0] G1F = pmd_pkg::REG_PHY_CONTROL_TWO;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic mgmt_clk, mgmt_data_in, mgmt_data_out, mgmt_data_oe, st_out, st_oe;
    logic [2:0] address_strap = 3'h5;
    logic [2:0] config_strap = 3'h6;
    logic small_package = 1'b0, partner_eee = 1'b0, link_up = 1'b0;
    logic link_speed100 = 1'b0, link_full_duplex = 1'b0, activity = 1'b0;
    logic [7:0] int_events = 8'h00;
    pmd_pkg::pmd_nib_t mac_tx = '0, line_rx = '0, mac_rx, line_tx;
    logic interrupt_output, status_light_first, status_light_second, shared_pin_txer;
    logic auto_mdix_en, mdix_swap, b2b_mode, b2b_10m, local_loopback, remote_loopback;
    logic [16:0] r;
    int fails = 0;
    int n_tests = 0;
    always #10 ref_clk = ~ref_clk;
    // pulled high when nobody drives
    assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : (st_oe ? st_out : 1'b1);
    pmd_top #(.BLINK_TICKS(4)) i_pmd_top (.*);
    pmd_station i_pmd_station (.*);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        i_pmd_station.xfer(pmd_pkg::OP_WRITE, pa, ra, d, r);
    endtask
    // a read nobody answers sees the pull-up on every bit
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [16:0] exp);
        i_pmd_station.xfer(pmd_pkg::OP_READ, pa, ra, 16'h0000, r);
        chk(r, exp);
    endtask
    task automatic pulse(input logic [7:0] e);
        @(negedge ref_clk) int_events = e;
        @(negedge ref_clk) int_events = 8'h00;
        repeat (3) @(negedge ref_clk);
    endtask
    // bits per light: ever off, always off
    task automatic lt(input logic [3:0] exp);
        logic [3:0] v;
        repeat (8) @(negedge ref_clk);
        v = 4'h5;
        repeat (24) begin
            @(negedge ref_clk);
            v = v | {status_light_first, 1'b0, status_light_second, 1'b0};
            v = v & {1'b1, status_light_first, 1'b1, status_light_second};
        end
        chk(17'(v), 17'(exp));
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(A, G0, 17'h03100);
        rd(A, G1F, 17'h02000);
        chk(17'(b2b_mode), 17'h1);
        chk(17'(auto_mdix_en), 17'h1);
        chk(17'(interrupt_output), 17'h1);
        $display("reset values done");
    endtask
    task automatic t_addr;
        wr(5'h00, G18, 16'h0040);
        rd(A, G18, 17'h00040);
        chk(17'(b2b_10m), 17'h1);
        wr(5'h03, G18, 16'h0000);
        rd(A, G18, 17'h00040);
        rd(5'h00, G18, 17'h1FFFF);
        rd(5'h03, G18, 17'h1FFFF);
        rd(5'h0D, G18, 17'h1FFFF);
        wr(A, 5'h10, 16'hFFFF);
        rd(A, 5'h10, 17'h00000);
        $display("addressing done");
    endtask
    task automatic t_irq;
        wr(A, G1B, 16'h0100);
        pulse(8'h03);
        chk(17'(interrupt_output), 17'h0);
        rd(A, G1B, 17'h00103);
        chk(17'(interrupt_output), 17'h1);
        rd(A, G1B, 17'h00100);
        pulse(8'h02);
        chk(17'(interrupt_output), 17'h1);
        wr(A, G1F, 16'h2200);
        chk(17'(interrupt_output), 17'h0);
        $display("interrupt done");
    endtask
    task automatic t_lights;
        lt(4'hF);
        link_up = 1'b1;
        link_speed100 = 1'b1;
        lt(4'h0);
        link_speed100 = 1'b0;
        lt(4'h3);
        activity = 1'b1;
        lt(4'hB);
        wr(A, G1F, 16'h2210);
        lt(4'h2);
        activity = 1'b0;
        lt(4'h3);
        $display("lights done");
    endtask
    task automatic t_loop;
        wr(A, G0, 16'h7100);
        wr(A, G1C, 16'h0021);
        chk(17'(local_loopback), 17'h0);
        wr(A, G0, 16'h6100);
        chk(17'(local_loopback), 17'h1);
        @(negedge ref_clk) mac_tx = '{1'b1, 4'hA};
        @(negedge ref_clk) chk(17'(mac_rx), 17'h0001A);
        chk(17'(shared_pin_txer), 17'h0);
        small_package = 1'b1;
        partner_eee = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(17'(shared_pin_txer), 17'h1);
        link_full_duplex = 1'b1;
        wr(A, G1F, 16'h4004);
        chk(17'(mdix_swap), 17'h1);
        chk(17'(auto_mdix_en), 17'h0);
        chk(17'(remote_loopback), 17'h0);
        link_speed100 = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(17'(remote_loopback), 17'h1);
        line_rx = '{1'b1, 4'h5};
        @(negedge ref_clk) chk(17'(line_tx), 17'h00015);
        $display("loopback done");
    endtask
    task automatic results;
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (8) @(negedge ref_clk);
        t_reset;
        t_addr;
        t_irq;
        t_lights;
        t_loop;
        results;
    end
    // frames take about 520 cycles each, some 20 of them
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        results;
    end
endmodule // pmd_top_bench
